// ### src/relay_setpoint_controller.sv
module relay_setpoint_controller #(
  parameter int NUM_RELAYS      = 6,
  parameter bit SIX_RELAY_MODEL = 1'b1
) (
  input  wire logic                     core_clk_in,
  input  wire logic                     sys_rst_in,
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [11:0]              paddr_in,
  input  wire logic [31:0]              pwdata_in,
  output logic      [31:0]              prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  input  wire relay_pkg::process_in_type proc_in,
  input  wire logic                     echo_loss_in,
  input  wire logic                     cable_fault_in,
  input  wire logic                     flush_request_in,
  input  wire logic                     flow_tick_in,
  input  wire logic                     time_tick_in,
  output logic [NUM_RELAYS-1:0]         relay_out
);

  // Refuse relay counts outside 1 to 6, or other than 1 or 3 without the six-relay model
  if (NUM_RELAYS < 1 || NUM_RELAYS > 6 ||
      (!SIX_RELAY_MODEL && NUM_RELAYS != 1 && NUM_RELAYS != 3)) begin : g_bad
    $error("relay_setpoint_controller: unsupported NUM_RELAYS");
  end

  // Per-relay settings, indexed by relay
  logic [7:0]          code_q  [NUM_RELAYS];
  relay_pkg::sp_type   on_q    [NUM_RELAYS];
  relay_pkg::sp_type   off_q   [NUM_RELAYS];
  logic [15:0]         scale_q [NUM_RELAYS];
  logic [15:0]         intvl_q [NUM_RELAYS];
  logic [23:0]         flow_q  [NUM_RELAYS];  // Flow units since last pulse
  logic [15:0]         tcnt_q  [NUM_RELAYS];  // Time ticks since last pulse
  logic [2:0]          pulse_q [NUM_RELAYS];  // Remaining pulse cycles
  logic [7:0]          eff     [NUM_RELAYS];  // Code after variant filter
  logic [NUM_RELAYS-1:0] comm_q;              // Remote command bits
  logic [NUM_RELAYS-1:0] relay_q;             // Relay active states
  logic [NUM_RELAYS-1:0] act_d;               // Next relay states
  logic [NUM_RELAYS-1:0] pump_mask;           // Relays in pump group
  logic [NUM_RELAYS-1:0] fire;                // Flow/time pulse events
  logic [2:0]          rot_q;                 // Duty rotation pointer
  logic                pump_was_q;            // Pump group ran last cycle
  logic                single_taken;          // Backup slot claimed
  logic [2:0]          pin_s1_q;              // Synchroniser first stage
  logic [2:0]          pin_s2_q;              // {flush, cable, echo}
  logic [31:0]         prdata_q;
  logic                hit;
  logic [2:0]          ridx;
  logic [2:0]          fld;

  // Variant filter on function codes
  function automatic logic supported(input logic [7:0] c);
    if (SIX_RELAY_MODEL) begin
      return c inside {[relay_pkg::FN_OFF:relay_pkg::FN_CABLE], relay_pkg::FN_TOTAL,
                       relay_pkg::FN_SAMPLE, [relay_pkg::FN_FIX_ASSIST:relay_pkg::FN_FIFO],
                       relay_pkg::FN_FLUSH, relay_pkg::FN_COMM};
    end
    return c inside {relay_pkg::FN_OFF, relay_pkg::FN_LEVEL, relay_pkg::FN_ECHO,
                     relay_pkg::FN_CABLE, relay_pkg::FN_FIX_ASSIST,
                     relay_pkg::FN_ALT_ASSIST, relay_pkg::FN_COMM};
  endfunction

  // Setpoint hysteresis; either direction of ON versus OFF
  function automatic logic hyst(input relay_pkg::sp_type v, input relay_pkg::sp_type on,
                                input relay_pkg::sp_type off, input logic prev);
    return (on >= off) ? ((v >= on) ? 1'b1 : ((v <= off) ? 1'b0 : prev))
                       : ((v <= on) ? 1'b1 : ((v >= off) ? 1'b0 : prev));
  endfunction

  // Clamp a written setpoint into its legal range
  function automatic relay_pkg::sp_type clamp_sp(input relay_pkg::sp_type v);
    return (v < relay_pkg::SP_MIN) ? relay_pkg::SP_MIN : ((v > relay_pkg::SP_MAX) ? relay_pkg::SP_MAX : v);
  endfunction

  // Local code to packed fieldbus number
  function automatic logic [7:0] to_bus(input logic [7:0] c);
    return (c <= relay_pkg::FN_CABLE) ? c :
           (c <= relay_pkg::FN_SAMPLE) ? 8'(c - relay_pkg::GAP_FLOW) :
           (c <= relay_pkg::FN_FIFO) ? 8'(c - relay_pkg::GAP_PUMP) : 8'(c - relay_pkg::GAP_CTRL);
  endfunction

  // Packed fieldbus number back to local code
  function automatic logic [7:0] from_bus(input logic [7:0] b);
    return (b <= relay_pkg::FN_CABLE) ? b :
           (b <= 8'(relay_pkg::FN_SAMPLE - relay_pkg::GAP_FLOW)) ? 8'(b + relay_pkg::GAP_FLOW) :
           (b <= 8'(relay_pkg::FN_FIFO - relay_pkg::GAP_PUMP)) ? 8'(b + relay_pkg::GAP_PUMP) :
           8'(b + relay_pkg::GAP_CTRL);
  endfunction

  // Ten to a small power; exponent saturates to keep 24 bits
  function automatic logic [23:0] pow10(input logic [3:0] e);
    logic [23:0] p;
    p = 24'h000001;
    for (int k = 0; k < int'(relay_pkg::POW_MAX); k++) begin
      if (k < int'(e)) begin
        p = 24'(p * 24'h00000a);
      end
    end
    return p;
  endfunction

  // Relay whose setpoints this pump borrows under rotation; a FIFO pump takes only its ON setpoint
  function automatic int rot_idx(input int i, input logic [2:0] r);
    return (i + int'(r) >= NUM_RELAYS) ? i + int'(r) - NUM_RELAYS : i + int'(r);
  endfunction

  // Two-stage synchroniser for the status pins
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {flush_request_in, cable_fault_in, echo_loss_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Address decode; bad alignment and holes answer with an error
  always_comb begin
    ridx = paddr_in[7:5];
    fld  = paddr_in[4:2];
    hit  = (paddr_in[1:0] == 2'h0) &&
           (paddr_in == relay_pkg::OFS_STATUS || paddr_in == relay_pkg::OFS_COMM ||
            (paddr_in[11:8] == relay_pkg::RELAY_PAGE && int'(ridx) < NUM_RELAYS && fld <= relay_pkg::FLD_INTVL));
  end

  // Zero wait states; data was latched in the setup cycle
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~hit;
  assign prdata_out  = prdata_q;

  // Read mux, sampled in the setup cycle
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      prdata_q <= 32'h0;
    end else if (psel_in && !penable_in) begin
      if (!hit) begin
        prdata_q <= 32'h0;
      end else if (paddr_in == relay_pkg::OFS_STATUS) begin
        prdata_q <= {21'h0, rot_q, 8'(relay_q)};
      end else if (paddr_in == relay_pkg::OFS_COMM) begin
        prdata_q <= {24'h0, 8'(comm_q)};
      end else begin
        case (fld)
          relay_pkg::FLD_CODE:    prdata_q <= {24'h0, code_q[ridx]};
          relay_pkg::FLD_ON:      prdata_q <= 32'(on_q[ridx]);
          relay_pkg::FLD_OFF:     prdata_q <= 32'(off_q[ridx]);
          relay_pkg::FLD_BUSCODE: prdata_q <= {24'h0, to_bus(code_q[ridx])};
          relay_pkg::FLD_SCALE:   prdata_q <= {16'h0, scale_q[ridx]};
          relay_pkg::FLD_INTVL:   prdata_q <= {16'h0, intvl_q[ridx]};
          default:                prdata_q <= 32'h0;
        endcase
      end
    end
  end

  // Settings written at the access edge
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      comm_q <= '0;
      for (int i = 0; i < NUM_RELAYS; i++) begin
        code_q[i]  <= relay_pkg::FN_OFF;
        on_q[i]    <= relay_pkg::SP_RST;
        off_q[i]   <= relay_pkg::SP_RST;
        scale_q[i] <= relay_pkg::SCALE_RST;
        intvl_q[i] <= relay_pkg::INTVL_RST;
      end
    end else if (psel_in && penable_in && pwrite_in && hit) begin
      if (paddr_in == relay_pkg::OFS_COMM) begin
        comm_q <= pwdata_in[NUM_RELAYS-1:0];
      end else if (paddr_in[11:8] == relay_pkg::RELAY_PAGE) begin
        case (fld)
          relay_pkg::FLD_CODE:    code_q[ridx]  <= pwdata_in[7:0];
          relay_pkg::FLD_ON:      on_q[ridx]    <= clamp_sp(pwdata_in[15:0]);
          relay_pkg::FLD_OFF:     off_q[ridx]   <= clamp_sp(pwdata_in[15:0]);
          relay_pkg::FLD_BUSCODE: code_q[ridx]  <= from_bus(pwdata_in[7:0]);
          relay_pkg::FLD_SCALE:   scale_q[ridx] <= pwdata_in[15:0];
          relay_pkg::FLD_INTVL:   intvl_q[ridx] <= pwdata_in[15:0];
          default:                code_q[ridx]  <= code_q[ridx];
        endcase
      end
    end
  end

  // Effective code and pump group membership
  always_comb begin
    for (int i = 0; i < NUM_RELAYS; i++) begin
      eff[i]       = supported(code_q[i]) ? code_q[i] : relay_pkg::FN_OFF;
      pump_mask[i] = eff[i] inside {[relay_pkg::FN_FIX_ASSIST:relay_pkg::FN_FIFO]};
    end
  end

  // Flow totaliser and sampler counters
  always_ff @(posedge core_clk_in) begin
    for (int i = 0; i < NUM_RELAYS; i++) begin
      if (sys_rst_in || !(eff[i] inside {relay_pkg::FN_TOTAL, relay_pkg::FN_SAMPLE})) begin
        flow_q[i]  <= 24'h0;
        tcnt_q[i]  <= 16'h0;
        pulse_q[i] <= 3'h0;
      end else begin
        if (fire[i]) begin
          flow_q[i] <= 24'h0;
        end else if (flow_tick_in) begin
          flow_q[i] <= 24'(flow_q[i] + 24'h000001);
        end
        if (fire[i] || intvl_q[i] == 16'h0) begin
          tcnt_q[i] <= 16'h0;
        end else if (time_tick_in && eff[i] == relay_pkg::FN_SAMPLE) begin
          tcnt_q[i] <= 16'(tcnt_q[i] + 16'h0001);
        end
        // Fixed-width pulse; events during a pulse are dropped
        if (fire[i] && pulse_q[i] == 3'h0) begin
          pulse_q[i] <= 3'(relay_pkg::PULSE_CYC);
        end else if (pulse_q[i] != 3'h0) begin
          pulse_q[i] <= 3'(pulse_q[i] - 3'h1);
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_RELAYS; i++) begin
      logic [3:0]  e;
      logic [7:0]  m;
      logic [23:0] tgt;
      e   = scale_q[i][relay_pkg::SCL_EXP_LSB +: 4];
      m   = scale_q[i][relay_pkg::SCL_MUL_LSB +: 8];
      if (e > relay_pkg::POW_MAX) begin
        e = relay_pkg::POW_MAX;
      end
      tgt = pow10(e);
      if (eff[i] == relay_pkg::FN_SAMPLE && m != 8'h0) begin
        tgt = 24'(tgt * {16'h0, m});
      end
      fire[i] = (flow_tick_in && flow_q[i] == 24'(tgt - 24'h000001)) ||
                (eff[i] == relay_pkg::FN_SAMPLE && intvl_q[i] != 16'h0 &&
                 time_tick_in && tcnt_q[i] == 16'(intvl_q[i] - 16'h0001));
    end
  end

  // Activation algorithm per relay
  always_comb begin
    single_taken = 1'b0;
    for (int i = 0; i < NUM_RELAYS; i++) begin
      int r;
      r = rot_idx(i, rot_q);
      case (eff[i])
        relay_pkg::FN_LEVEL:  act_d[i] = hyst(proc_in.level, on_q[i], off_q[i], relay_q[i]);
        relay_pkg::FN_INB:    act_d[i] = proc_in.level <= on_q[i] && proc_in.level >= off_q[i];
        relay_pkg::FN_OUTB:   act_d[i] = proc_in.level > on_q[i] || proc_in.level < off_q[i];
        relay_pkg::FN_RATE:   act_d[i] = hyst(proc_in.rate, on_q[i], off_q[i], relay_q[i]);
        relay_pkg::FN_TEMP:   act_d[i] = hyst(proc_in.temp, on_q[i], off_q[i], relay_q[i]);
        relay_pkg::FN_ECHO:   act_d[i] = pin_s2_q[0];
        relay_pkg::FN_CABLE:  act_d[i] = pin_s2_q[1];
        relay_pkg::FN_TOTAL,
        relay_pkg::FN_SAMPLE: act_d[i] = pulse_q[i] != 3'h0;
        relay_pkg::FN_FIX_ASSIST,
        relay_pkg::FN_FIX_BACKUP: act_d[i] = hyst(proc_in.level, on_q[i], off_q[i], relay_q[i]);
        relay_pkg::FN_ALT_ASSIST, relay_pkg::FN_ALT_BACKUP,
        relay_pkg::FN_SR_ASSIST, relay_pkg::FN_SR_BACKUP:
          act_d[i] = hyst(proc_in.level, on_q[r], off_q[r], relay_q[i]);
        relay_pkg::FN_FIFO:   act_d[i] = hyst(proc_in.level, on_q[r], off_q[i], relay_q[i]);
        relay_pkg::FN_FLUSH:  act_d[i] = pin_s2_q[2];
        relay_pkg::FN_COMM:   act_d[i] = comm_q[i];
        default:              act_d[i] = 1'b0;
      endcase
      // backup: one pump at a time, a running pump keeps its slot
      if (eff[i] inside {relay_pkg::FN_FIX_BACKUP, relay_pkg::FN_ALT_BACKUP,
                         relay_pkg::FN_SR_BACKUP} && act_d[i] && !relay_q[i]) begin
        if (single_taken || |(relay_q & pump_mask)) begin
          act_d[i] = 1'b0;
        end
      end
      if (act_d[i] && pump_mask[i]) begin
        single_taken = 1'b1;
      end
    end
  end

  // Relay state register
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      relay_q <= '0;
    end else begin
      relay_q <= act_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rot_q      <= 3'h0;
      pump_was_q <= 1'b0;
    end else begin
      pump_was_q <= |(relay_q & pump_mask);
      if (pump_was_q && !(|(relay_q & pump_mask))) begin
        rot_q <= (int'(rot_q) >= NUM_RELAYS - 1) ? 3'h0 : 3'(rot_q + 3'h1);
      end
    end
  end

  assign relay_out = relay_q;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_pulse_run;
    relay_q[0] [*4] ##1 !relay_q[0];
  endsequence

  a_off_code_idle: assert property (eff[0] == relay_pkg::FN_OFF |=> !relay_q[0])
    else $error("relay 0 active with function off");
  a_level_on_trip: assert property (eff[0] == relay_pkg::FN_LEVEL && on_q[0] > off_q[0] &&
    proc_in.level >= on_q[0] |=> relay_q[0]) else $error("level ON setpoint missed");
  a_level_off_reset: assert property (eff[0] == relay_pkg::FN_LEVEL && on_q[0] > off_q[0] &&
    proc_in.level <= off_q[0] |=> !relay_q[0]) else $error("level OFF setpoint missed");
  a_level_hold: assert property (eff[0] == relay_pkg::FN_LEVEL && on_q[0] > off_q[0] &&
    proc_in.level < on_q[0] && proc_in.level > off_q[0] |=> relay_q[0] == $past(relay_q[0]))
    else $error("hysteresis not held");
  a_inbound_active: assert property (eff[0] == relay_pkg::FN_INB
    |=> relay_q[0] == ($past(proc_in.level) <= $past(on_q[0]) && $past(proc_in.level) >= $past(off_q[0])))
    else $error("in-bounds state wrong");
  a_outbound_active: assert property (eff[0] == relay_pkg::FN_OUTB &&
    (proc_in.level > on_q[0] || proc_in.level < off_q[0]) |=> relay_q[0]) else $error("out-of-bounds missed");
  a_echo_follow: assert property (eff[0] == relay_pkg::FN_ECHO |=> relay_q[0] == $past(pin_s2_q[0]))
    else $error("echo loss not followed");
  a_comm_follow: assert property (eff[0] == relay_pkg::FN_COMM |=> relay_q[0] == $past(comm_q[0]))
    else $error("remote command not followed");
  a_unsupported_off: assert property (!supported(code_q[0]) |=> !relay_q[0])
    else $error("unsupported code drove relay");
  a_pulse_width: assert property (eff[0] == relay_pkg::FN_TOTAL && fire[0] && pulse_q[0] == 3'h0 &&
    $stable(eff[0]) ##1 $stable(eff[0]) |=> s_pulse_run) else $error("flow pulse width wrong");

endmodule

// ### src/relay_pkg.sv
package relay_pkg;
  // Local function codes, one per relay
  localparam logic [7:0] FN_OFF        = 8'h00;
  localparam logic [7:0] FN_LEVEL      = 8'h01;
  localparam logic [7:0] FN_INB        = 8'h02;
  localparam logic [7:0] FN_OUTB       = 8'h03;
  localparam logic [7:0] FN_RATE       = 8'h04;
  localparam logic [7:0] FN_TEMP       = 8'h05;
  localparam logic [7:0] FN_ECHO       = 8'h06;
  localparam logic [7:0] FN_CABLE      = 8'h07;
  localparam logic [7:0] FN_TOTAL      = 8'h28;
  localparam logic [7:0] FN_SAMPLE     = 8'h29;
  localparam logic [7:0] FN_FIX_ASSIST = 8'h32;
  localparam logic [7:0] FN_FIX_BACKUP = 8'h33;
  localparam logic [7:0] FN_ALT_ASSIST = 8'h34;
  localparam logic [7:0] FN_ALT_BACKUP = 8'h35;
  localparam logic [7:0] FN_SR_ASSIST  = 8'h36;
  localparam logic [7:0] FN_SR_BACKUP  = 8'h37;
  localparam logic [7:0] FN_FIFO       = 8'h38;
  localparam logic [7:0] FN_FLUSH      = 8'h40;
  localparam logic [7:0] FN_COMM       = 8'h41;
  // Gaps between local codes and packed fieldbus numbering
  localparam logic [7:0] GAP_FLOW      = 8'h20;
  localparam logic [7:0] GAP_PUMP      = 8'h28;
  localparam logic [7:0] GAP_CTRL      = 8'h2f;
  // Setpoint range in span units
  localparam logic signed [15:0] SP_MIN = 16'shfc19;
  localparam logic signed [15:0] SP_MAX = 16'sh270f;
  // Register map
  localparam logic [11:0] OFS_STATUS   = 12'h000;
  localparam logic [11:0] OFS_COMM     = 12'h004;
  localparam logic [3:0]  RELAY_PAGE   = 4'h1;
  localparam logic [2:0]  FLD_CODE     = 3'h0;
  localparam logic [2:0]  FLD_ON       = 3'h1;
  localparam logic [2:0]  FLD_OFF      = 3'h2;
  localparam logic [2:0]  FLD_BUSCODE  = 3'h3;
  localparam logic [2:0]  FLD_SCALE    = 3'h4;
  localparam logic [2:0]  FLD_INTVL    = 3'h5;
  // Scale field layout and reset values
  localparam int          SCL_EXP_LSB  = 0;
  localparam int          SCL_MUL_LSB  = 8;
  localparam logic [3:0]  POW_MAX      = 4'h6;
  localparam logic [15:0] SCALE_RST    = 16'h0100;
  localparam logic [15:0] INTVL_RST    = 16'h0000;
  localparam logic signed [15:0] SP_RST = 16'sh0000;
  // Timing: 40 ns clock, 160 ns least pulse
  localparam int          CLK_NS       = 32'h28;
  localparam int          PULSE_NS     = 32'ha0;
  localparam int          PULSE_CYC    = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  // Carriers
  typedef logic signed [15:0] sp_type;
  typedef struct packed {
    sp_type level;
    sp_type rate;
    sp_type temp;
  } process_in_type;
endpackage

// ### sim/relay_contacts.sv
module relay_contacts (
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [5:0] coil_in,
  output logic      [5:0] contact_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Armature lags coil by a clock; all open in reset
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      contact_out <= 6'h00;
    end else begin
      contact_out <= coil_in;
    end
  end
endmodule

// ### sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, pen, pwr, pready, slverr, flow, tick, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] pins;
  logic [5:0] rly_o, cont;
  relay_pkg::process_in_type proc;
  int failures, tests_run;
  relay_setpoint_controller relay_setpoint_controller_i (.core_clk_in(clk), .sys_rst_in(rst),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(slverr), .proc_in(proc),
    .echo_loss_in(pins[0]), .cable_fault_in(pins[1]), .flush_request_in(pins[2]),
    .flow_tick_in(flow), .time_tick_in(tick), .relay_out(rly_o));
  relay_contacts relay_contacts_i (.core_clk_in(clk), .sys_rst_in(rst), .coil_in(rly_o),
    .contact_out(cont));
  // Free running 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; waits up to 50 cycles for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = slverr;
    chk("pready", {31'h0, pready}, 32'h1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("rdata", rd, e);
  endtask
  function automatic logic [11:0] ra(input int i, input logic [2:0] f);
    return {relay_pkg::RELAY_PAGE, 8'h00} + (12'(i) << 5) + {7'h00, f, 2'b00};
  endfunction
  task automatic setup(input int i, input logic [7:0] c, input logic [31:0] on, off);
    apb(1'b1, ra(i, relay_pkg::FLD_CODE), {24'h0, c});
    apb(1'b1, ra(i, relay_pkg::FLD_ON), on);
    apb(1'b1, ra(i, relay_pkg::FLD_OFF), off);
  endtask
  // Let pins sync and contacts settle
  task automatic rly(input logic [1:0] e);
    repeat (5) @(posedge clk);
    #1;
    chk("contacts", {26'h0, cont}, {30'h0, e});
  endtask
  // Walk one process value, expect relay pair states
  task automatic sweep(input int s, input relay_pkg::sp_type v[5], input logic [1:0] e[5]);
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      if (s == 0) proc.level <= v[k];
      else if (s == 1) proc.rate <= v[k];
      else proc.temp <= v[k];
      rly(e[k]);
    end
  endtask
  task automatic t_setpt();
    setup(0, relay_pkg::FN_LEVEL, 32'd100, 32'd20);
    sweep(0, '{0, 100, 50, 20, 50}, '{0, 1, 1, 0, 0});
    setup(0, relay_pkg::FN_INB, 32'd100, 32'd20);
    sweep(0, '{50, 150, 10, 20, 100}, '{1, 0, 0, 1, 1});
    setup(0, relay_pkg::FN_OUTB, 32'd100, 32'd20);
    sweep(0, '{150, 50, 10, 20, 0}, '{1, 0, 1, 0, 1});
    setup(0, relay_pkg::FN_RATE, 32'd100, 32'd20);
    sweep(1, '{100, 50, 20, 0, 50}, '{1, 1, 0, 0, 0});
    setup(0, relay_pkg::FN_TEMP, 32'd100, 32'd20);
    sweep(2, '{100, 50, 20, 0, 50}, '{1, 1, 0, 0, 0});
  endtask
  task automatic t_pins();
    logic [7:0] c[3] = '{relay_pkg::FN_ECHO, relay_pkg::FN_CABLE, relay_pkg::FN_FLUSH};
    for (int k = 0; k < 3; k++) begin
      setup(0, c[k], 32'h0, 32'h0);
      pins <= 3'(1 << k);
      rly(2'b01);
      pins <= 3'h0;
      rly(2'b00);
    end
  endtask
  task automatic t_comm();
    setup(0, relay_pkg::FN_COMM, 32'h0, 32'h0);
    apb(1'b1, relay_pkg::OFS_COMM, 32'h3);
    rly(2'b01);
    rdc(relay_pkg::OFS_STATUS, 32'h1);
    rdc(relay_pkg::OFS_COMM, 32'h3);
    apb(1'b1, relay_pkg::OFS_COMM, 32'h0);
    rly(2'b00);
  endtask
  task automatic t_pump();
    setup(0, relay_pkg::FN_FIX_ASSIST, 32'd100, 32'd20);
    setup(1, relay_pkg::FN_FIX_ASSIST, 32'd150, 32'd20);
    sweep(0, '{0, 120, 160, 10, 0}, '{0, 1, 3, 0, 0});
    setup(0, relay_pkg::FN_FIX_BACKUP, 32'd100, 32'd20);
    setup(1, relay_pkg::FN_FIX_BACKUP, 32'd150, 32'd20);
    sweep(0, '{160, 100, 10, 0, 0}, '{1, 1, 0, 0, 0});
  endtask
  // Hold flow (tm=0) or time (tm=1) ticks for n edges, then count pulse
  task automatic ticks(input logic tm, input int n, output int hi);
    @(posedge clk);
    if (tm) begin
      tick <= 1'b1;
    end else begin
      flow <= 1'b1;
    end
    repeat (n) @(posedge clk);
    flow <= 1'b0;
    tick <= 1'b0;
    hi = 0;
    repeat (12) begin
      @(posedge clk);
      #1;
      hi += int'(rly_o[0]);
    end
  endtask
  task automatic t_total();
    int hi;
    setup(0, relay_pkg::FN_TOTAL, 32'h0, 32'h0);
    apb(1'b1, ra(0, relay_pkg::FLD_SCALE), 32'h0101);
    ticks(1'b0, 9, hi);
    chk("early pulse", 32'(hi), 32'h0);
    ticks(1'b0, 1, hi);
    chk("pulse width", 32'(hi), 32'h4);
  endtask
  // Sampler: pulse after interval time ticks, then after mult x 10^exp flow
  task automatic t_sample();
    int hi;
    setup(0, relay_pkg::FN_SAMPLE, 32'h0, 32'h0);
    apb(1'b1, ra(0, relay_pkg::FLD_INTVL), 32'h3);
    ticks(1'b1, 2, hi);
    chk("early sample", 32'(hi), 32'h0);
    ticks(1'b1, 1, hi);
    chk("time sample", 32'(hi), 32'h4);
    apb(1'b1, ra(0, relay_pkg::FLD_SCALE), 32'h0201);
    ticks(1'b0, 19, hi);
    chk("early flow sample", 32'(hi), 32'h0);
    ticks(1'b0, 1, hi);
    chk("flow sample", 32'(hi), 32'h4);
  endtask
  task automatic t_regs();
    rdc(ra(0, relay_pkg::FLD_BUSCODE), 32'h8);
    apb(1'b1, ra(0, relay_pkg::FLD_BUSCODE), 32'h12);
    rdc(ra(0, relay_pkg::FLD_CODE), 32'h41);
    setup(0, 8'h10, 32'h2710, 32'hfffffc00);
    proc.level <= 16'sd200;
    rly(2'b10);
    rdc(ra(0, relay_pkg::FLD_CODE), 32'h10);
    rdc(ra(0, relay_pkg::FLD_ON), 32'h270f);
    rdc(ra(0, relay_pkg::FLD_OFF), 32'hfffffc19);
    rdc(12'h080, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Hang guard, well past the whole sequence
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end
  initial begin
    {psel, pen, pwr, flow, tick, paddr, pwdata, pins, proc} <= '0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rly(2'b00);
    rdc(relay_pkg::OFS_STATUS, 32'h0);
    rdc(ra(0, relay_pkg::FLD_CODE), 32'h0);
    t_setpt();
    t_pins();
    t_comm();
    t_pump();
    t_total();
    t_regs();
    t_sample();
    finish_test();
  end
endmodule
